// ===== core/endpoint_decoder.sv
// maps a protocol endpoint address to a pipe index
`timescale 1ns/1ps
`default_nettype none
module endpoint_decoder
  import usb_xcvr_pkg::*;
(
  input wire logic [7:0] ep_address,
  output logic ep_hit,
  output logic [2:0] ep_pipe
);
  // -------------------------------------------------------------
  // decode
  // -------------------------------------------------------------
  // pipe = {dir,num}; endpoint 0 shares address 0x00 for both directions
  always_comb begin
    ep_hit = 1'b0;
    ep_pipe = 3'h0;
    if (ep_address[6:2] == 5'h00) begin
      if (ep_address[1:0] == 2'h0) begin
        ep_hit = (ep_address[7] == 1'b0);
        ep_pipe = 3'h0;
      end else begin
        ep_hit = 1'b1;
        ep_pipe = {ep_address[7], ep_address[1:0]};
      end
    end
  end
endmodule : endpoint_decoder
`default_nettype wire

// ===== core/line_sampler.sv
// two-stage sampler for one receive line level
`timescale 1ns/1ps
`default_nettype none
module line_sampler (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic level_in,
  output logic level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } samp_state_t;
  samp_state_t state_ff;
  samp_state_t nxt_state;

  // -------------------------------------------------------------
  // register stage
  // -------------------------------------------------------------
  // first stage feeds only the second, guards against metastability
  always_comb begin
    nxt_state.s1 = level_in;
    nxt_state.s2 = state_ff.s1;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign level_out = state_ff.s2;
endmodule : line_sampler
`default_nettype wire

// ===== core/usb_xcvr_ctrl.sv
// transceiver control register and pad steering for the usb function controller
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RULE1] eight pipes total, counted per direction across four endpoints
// [RULE2] endpoint 0 is always one bidirectional control pipe pair
// [RULE3] endpoints 1-3 in at 0x80+n, out at n; endpoint 0 at 0x00
// [RULE4] rate select 1: full speed, pull-up on plus line
// [RULE5] rate select 0: low speed, pull-up on minus line
// [RULE6] pull-up applied only while vbus is present
// [RULE7] firmware should start usb clock before enabling the transceiver
// [RULE8] peripheral function only, no host role
// [RULE9] bit7 pull-up, bit6 enable, bit5 rate, bits4:3 test; rw, reset zero
// [RULE10] low five bits for testing; bits2:0 live receiver, plus, minus status
// [RULE11] controller holds engine, transceiver, 1 kB fifo, clock recovery
// [RULE12] test 00 normal, 01 diff 1, 10 diff 0, 11 single-ended zero
// [RULE13] pull-up enable clear keeps device detached
// [RULE14] transceiver enable clear holds phy in suspend
// [RULE15] receiver bit shows differential state while transceiver enabled
// [RULE16] writes to status bits ignored; reads return sampled line state
module usb_xcvr_ctrl
  import usb_xcvr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic vbus_present,
  input wire logic plus_line_in,
  input wire logic minus_line_in,
  input wire logic diff_receiver_in,
  output logic plus_line_out,
  output logic plus_line_oe,
  output logic minus_line_out,
  output logic minus_line_oe,
  output logic plus_pullup_on,
  output logic minus_pullup_on,
  output logic transceiver_suspend,
  output logic full_speed,
  input wire logic [7:0] ep_address,
  output logic ep_hit,
  output logic [2:0] ep_pipe
);
  import usb_xcvr_pkg::*;

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    logic pullup_attach_enable;
    logic transceiver_enable;
    logic rate_select;
    line_test_mode_t line_test_mode;
    logic diff_receiver_state;
    logic plus_line_level;
    logic minus_line_level;
    logic plus_out;
    logic plus_oe;
    logic minus_out;
    logic minus_oe;
    logic plus_pu;
    logic minus_pu;
    logic suspend;
    logic ep_hit;
    logic [2:0] ep_pipe;
  } ctrl_state_t;

  ctrl_state_t state_ff;
  ctrl_state_t nxt_state;
  logic plus_sync;
  logic minus_sync;
  logic diff_sync;
  logic dec_hit;
  logic [2:0] dec_pipe;

  // -------------------------------------------------------------
  // line samplers
  // -------------------------------------------------------------
  line_sampler u_plus (
    .sys_clk(sys_clk),
    .rst(rst),
    .level_in(plus_line_in),
    .level_out(plus_sync)
  );

  line_sampler u_minus (
    .sys_clk(sys_clk),
    .rst(rst),
    .level_in(minus_line_in),
    .level_out(minus_sync)
  );

  line_sampler u_diff (
    .sys_clk(sys_clk),
    .rst(rst),
    .level_in(diff_receiver_in),
    .level_out(diff_sync)
  );

  // -------------------------------------------------------------
  // endpoint address map
  // -------------------------------------------------------------
  // four endpoints x two directions gives the fixed pipe count
  endpoint_decoder u_ep_dec (
    .ep_address(ep_address),
    .ep_hit(dec_hit),
    .ep_pipe(dec_pipe)
  ); // [RULE1] [RULE2] [RULE3]

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  // no host role exists here: the pads are only driven in test modes [RULE8]
  always_comb begin
    nxt_state = state_ff;
    // control fields are plain read/write; status bits not writable
    if (reg_wr) begin
      nxt_state.pullup_attach_enable = reg_wdata[PULLUP_BIT]; // [RULE9]
      nxt_state.transceiver_enable = reg_wdata[XCVR_EN_BIT]; // [RULE9]
      nxt_state.rate_select = reg_wdata[RATE_BIT]; // [RULE9]
      nxt_state.line_test_mode =
        line_test_mode_t'(reg_wdata[TEST_HI_BIT:TEST_LO_BIT]); // [RULE9] [RULE10]
    end
    // status follows the sampled pins regardless of writes [RULE16]
    nxt_state.plus_line_level = plus_sync; // [RULE10]
    nxt_state.minus_line_level = minus_sync; // [RULE10]
    // receiver output only meaningful while the phy runs
    nxt_state.diff_receiver_state = nxt_state.transceiver_enable ? diff_sync : 1'b0; // [RULE15]
    nxt_state.suspend = ~nxt_state.transceiver_enable; // [RULE14]
    // pull-up needs both the enable and vbus; speed picks the line
    nxt_state.plus_pu = nxt_state.pullup_attach_enable & vbus_present
      & nxt_state.rate_select; // [RULE4] [RULE6] [RULE13]
    nxt_state.minus_pu = nxt_state.pullup_attach_enable & vbus_present
      & ~nxt_state.rate_select; // [RULE5] [RULE6] [RULE13]
    // forced line states; a suspended phy drives nothing
    nxt_state.plus_out = 1'b0;
    nxt_state.minus_out = 1'b0;
    nxt_state.plus_oe = 1'b0;
    nxt_state.minus_oe = 1'b0;
    if (nxt_state.transceiver_enable) begin
      case (nxt_state.line_test_mode)
        TEST_NORMAL: begin
          nxt_state.plus_oe = 1'b0; // [RULE12]
        end
        TEST_DIFF1: begin
          nxt_state.plus_out = 1'b1; // [RULE12]
          nxt_state.plus_oe = 1'b1;
          nxt_state.minus_oe = 1'b1;
        end
        TEST_DIFF0: begin
          nxt_state.minus_out = 1'b1; // [RULE12]
          nxt_state.plus_oe = 1'b1;
          nxt_state.minus_oe = 1'b1;
        end
        TEST_SE0: begin
          nxt_state.plus_oe = 1'b1; // [RULE12]
          nxt_state.minus_oe = 1'b1;
        end
        default: begin
          nxt_state.plus_oe = 1'b0;
        end
      endcase
    end
    // registered so every output comes from a flip-flop
    nxt_state.ep_hit = dec_hit;
    nxt_state.ep_pipe = dec_pipe;
  end

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  // all fields clear at reset except suspend, which sets so the phy is in suspend; pull-ups off
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.suspend <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  // read image straight from the flops; status bits are the live samples
  assign reg_rdata = {state_ff.pullup_attach_enable, state_ff.transceiver_enable,
    state_ff.rate_select, state_ff.line_test_mode, state_ff.diff_receiver_state,
    state_ff.plus_line_level, state_ff.minus_line_level}; // [RULE16]
  assign plus_line_out = state_ff.plus_out;
  assign plus_line_oe = state_ff.plus_oe;
  assign minus_line_out = state_ff.minus_out;
  assign minus_line_oe = state_ff.minus_oe;
  assign plus_pullup_on = state_ff.plus_pu;
  assign minus_pullup_on = state_ff.minus_pu;
  // usb clock must already run when firmware sets enable; not checked here [RULE7]
  assign transceiver_suspend = state_ff.suspend;
  assign full_speed = state_ff.rate_select;
  // engine and 1 kB fifo sit outside; this block feeds them pipe and speed [RULE11]
  assign ep_hit = state_ff.ep_hit;
  assign ep_pipe = state_ff.ep_pipe;
endmodule : usb_xcvr_ctrl
`default_nettype wire

// ===== core/usb_xcvr_pkg.sv
// constants, field layout and types for the transceiver control block
package usb_xcvr_pkg;
  // -------------------------------------------------------------
  // register layout
  // -------------------------------------------------------------
  localparam logic [7:0] XCN_RESET = 8'h00;
  localparam int PULLUP_BIT = 7;
  localparam int XCVR_EN_BIT = 6;
  localparam int RATE_BIT = 5;
  localparam int TEST_HI_BIT = 4;
  localparam int TEST_LO_BIT = 3;
  localparam int DIFF_BIT = 2;
  localparam int PLUS_BIT = 1;
  localparam int MINUS_BIT = 0;
  localparam logic [7:0] WRITE_MASK = 8'hf8;

  // -------------------------------------------------------------
  // endpoint addressing
  // -------------------------------------------------------------
  localparam int NUM_PIPES = 8;
  localparam int NUM_ENDPOINTS = 4;
  localparam logic [7:0] EP_DIR_IN = 8'h80;
  localparam logic [7:0] EP_CTRL_ADDR = 8'h00;
  localparam logic [1:0] EP_NUM_MAX = 2'h3;
  localparam int FIFO_BYTES = 1024;

  // line test modes, binary ordered along normal -> forced states
  typedef enum logic [1:0] {
    TEST_NORMAL = 2'b00,
    TEST_DIFF1 = 2'b01,
    TEST_DIFF0 = 2'b10,
    TEST_SE0 = 2'b11
  } line_test_mode_t;
endpackage : usb_xcvr_pkg

// ===== verification/usb_host_model.sv
// host end of the cable: resolves the pad levels the transceiver sees
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  input wire logic [1:0] host_lvl,
  input wire logic plus_line_oe,
  input wire logic plus_line_out,
  input wire logic minus_line_oe,
  input wire logic minus_line_out,
  input wire logic plus_pullup_on,
  input wire logic minus_pullup_on,
  output logic plus_line_in,
  output logic minus_line_in,
  output logic diff_receiver_in
);
  // host drives {plus, minus} unless 00; released lines follow the device pull-up, low without it
  wire logic hd = |host_lvl;
  // device drive wins, else host, else the device pull-up
  assign plus_line_in = plus_line_oe ? plus_line_out : hd ? host_lvl[1] : plus_pullup_on;
  assign minus_line_in = minus_line_oe ? minus_line_out : hd ? host_lvl[0] : minus_pullup_on;
  // differential 1 only while plus sits above minus
  assign diff_receiver_in = plus_line_in & ~minus_line_in;
endmodule : usb_host_model
`default_nettype wire

// ===== verification/usb_xcvr_ctrl_tb.sv
// self-checking bench: control writes, line status and endpoint lookup
`timescale 1ns/1ps
`default_nettype none
module usb_xcvr_ctrl_tb;
  logic sys_clk, rst, reg_wr, vbus_present, plus_line_in, minus_line_in, diff_receiver_in;
  logic plus_line_out, plus_line_oe, minus_line_out, minus_line_oe, plus_pullup_on;
  logic minus_pullup_on, transceiver_suspend, full_speed, ep_hit;
  logic [7:0] reg_wdata, reg_rdata, ep_address;
  logic [2:0] ep_pipe;
  logic [1:0] host_lvl;
  int failures = 0, n_compared = 0;
  // register image, pad drive and status outputs in one word
  wire logic [15:0] image = {reg_rdata, plus_line_oe, plus_line_out, minus_line_oe,
    minus_line_out, plus_pullup_on, minus_pullup_on, transceiver_suspend, full_speed};
  // expected image per line test mode, enabled and detached
  logic [15:0] mode_exp [4] = '{16'h4000, 16'h4ee0, 16'h51b0, 16'h58a0};
  usb_xcvr_ctrl i_usb_xcvr_ctrl (
    .sys_clk(sys_clk),
    .rst(rst),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .vbus_present(vbus_present),
    .plus_line_in(plus_line_in),
    .minus_line_in(minus_line_in),
    .diff_receiver_in(diff_receiver_in),
    .plus_line_out(plus_line_out),
    .plus_line_oe(plus_line_oe),
    .minus_line_out(minus_line_out),
    .minus_line_oe(minus_line_oe),
    .plus_pullup_on(plus_pullup_on),
    .minus_pullup_on(minus_pullup_on),
    .transceiver_suspend(transceiver_suspend),
    .full_speed(full_speed),
    .ep_address(ep_address),
    .ep_hit(ep_hit),
    .ep_pipe(ep_pipe)
  );
  usb_host_model i_usb_host_model (
    .host_lvl(host_lvl),
    .plus_line_oe(plus_line_oe),
    .plus_line_out(plus_line_out),
    .minus_line_oe(minus_line_oe),
    .minus_line_out(minus_line_out),
    .plus_pullup_on(plus_pullup_on),
    .minus_pullup_on(minus_pullup_on),
    .plus_line_in(plus_line_in),
    .minus_line_in(minus_line_in),
    .diff_receiver_in(diff_receiver_in)
  );
  // 40 MHz system clock
  initial begin
    sys_clk = 0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // strobe stays high for n of 0 so the next write lands back to back
  task automatic wr(input logic [7:0] d, input int n);
    reg_wr = 1;
    reg_wdata = d;
    @(negedge sys_clk);
    if (n > 0) reg_wr = 0;
    repeat (n) @(negedge sys_clk);
  endtask : wr
  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // pad status lags three edges, so each check after a write or a vbus change waits four
  initial begin
    {rst, reg_wr, vbus_present, host_lvl, reg_wdata, ep_address} = {3'b100, 18'h00000};
    repeat (5) @(negedge sys_clk);
    rst = 0;
    chk(image, 16'h0002, "reset");
    vbus_present = 1;
    wr(8'he7, 4); // usb clock taken as running before enable
    chk(image, 16'he609, "full speed");
    vbus_present = 0;
    repeat (4) @(negedge sys_clk);
    chk(image, 16'he001, "no vbus");
    vbus_present = 1;
    wr(8'hff, 0);
    wr(8'hc0, 4);
    chk(image, 16'hc104, "low speed");
    $display("attach test done");
    for (int m = 0; m < 4; m++) begin
      wr(mode_exp[m][15:8] | 8'h07, 4);
      chk(image, mode_exp[m], "line mode");
    end
    $display("line mode test done");
    host_lvl = 2'b10;
    wr(8'h08, 4);
    chk(image, 16'h0a02, "suspended");
    wr(8'h40, 4);
    chk(image, 16'h4600, "host diff 1");
    host_lvl = 2'b00;
    $display("host drive test done");
    for (int i = 0; i < 256; i++) begin
      logic hit;
      ep_address = 8'(i);
      hit = i inside {0, 1, 2, 3, 129, 130, 131};
      @(negedge sys_clk);
      chk(16'({ep_hit, ep_pipe}),
        16'(hit ? {1'b1, ep_address[7], ep_address[1:0]} : {1'b0, ep_pipe}), "endpoint");
    end
    $display("endpoint test done");
    // second reset mid-run while attached and enabled; held long enough for the status lag
    wr(8'he7, 1);
    rst = 1;
    @(negedge sys_clk);
    chk(image, 16'h0002, "in reset");
    repeat (4) @(negedge sys_clk);
    rst = 0;
    @(negedge sys_clk);
    chk(image, 16'h0002, "after reset");
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule : usb_xcvr_ctrl_tb
bind usb_xcvr_ctrl xcvr_props i_xcvr_props (
  .sys_clk(sys_clk),
  .rst(rst),
  .reg_wr(reg_wr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .vbus_present(vbus_present),
  .plus_line_in(plus_line_in),
  .minus_line_in(minus_line_in),
  .diff_receiver_in(diff_receiver_in),
  .plus_line_out(plus_line_out),
  .plus_line_oe(plus_line_oe),
  .minus_line_out(minus_line_out),
  .minus_line_oe(minus_line_oe),
  .plus_pullup_on(plus_pullup_on),
  .minus_pullup_on(minus_pullup_on),
  .transceiver_suspend(transceiver_suspend)
);
`default_nettype wire

// ===== verification/xcvr_props.sv
// assertions on the transceiver control ports
`timescale 1ns/1ps
`default_nettype none
module xcvr_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic vbus_present,
  input wire logic plus_line_in,
  input wire logic minus_line_in,
  input wire logic diff_receiver_in,
  input wire logic plus_line_out,
  input wire logic plus_line_oe,
  input wire logic minus_line_out,
  input wire logic minus_line_oe,
  input wire logic plus_pullup_on,
  input wire logic minus_pullup_on,
  input wire logic transceiver_suspend
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // enabled write of mode 01, then both pads forced
  sequence s_wr1;
    reg_wr && reg_wdata[6] && reg_wdata[4:3] == 2'b01;
  endsequence
  sequence s_drv1;
    plus_line_oe && plus_line_out && minus_line_oe && !minus_line_out;
  endsequence
  AST_WR: assert property (reg_wr |=> reg_rdata[7:3] == $past(reg_wdata[7:3]))
    else $error("control write lost");
  AST_PU_PLUS: assert property (
    plus_pullup_on == (reg_rdata[7] && reg_rdata[5] && $past(vbus_present)))
    else $error("plus pull-up wrong");
  AST_PU_MINUS: assert property (
    minus_pullup_on == (reg_rdata[7] && !reg_rdata[5] && $past(vbus_present)))
    else $error("minus pull-up wrong");
  AST_SUSPEND: assert property (transceiver_suspend == !reg_rdata[6])
    else $error("suspend wrong");
  AST_DIFF1: assert property (s_wr1 |=> s_drv1)
    else $error("diff 1 not forced");
  AST_NO_DRIVE: assert property (!reg_rdata[6] || reg_rdata[4:3] == 2'b00 |->
    !plus_line_oe && !minus_line_oe) else $error("pads driven");
  AST_PLUS: assert property (reg_rdata[1] == $past(plus_line_in, 3))
    else $error("plus status wrong");
  AST_MINUS: assert property (reg_rdata[0] == $past(minus_line_in, 3))
    else $error("minus status wrong");
  AST_DIFF: assert property (reg_rdata[6] && $past(reg_rdata[6], 3) |->
    reg_rdata[2] == $past(diff_receiver_in, 3)) else $error("diff status wrong");
endmodule : xcvr_props
`default_nettype wire
